// *** rts_sequencer.sv ***
`timescale 1ns/1ps
`include "rts_defines.svh"


module rts_sequencer #(
    parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = `RTS_POWERUP_DELAY_TIMER_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        POR_SIG,
    input  wire logic        MASTER_CLEAR_PIN_N,
    input  wire logic        OSC_INPUT_PIN,
    input  wire logic        OSC_AMPLITUDE_OK,
    input  wire logic [1:0]  OSC_MODE,
    input  wire logic        SLEEP_ENTER,
    input  wire logic        WDT_TIMEOUT,
    input  wire logic        WDT_CLEAR_INSTR,
    input  wire logic        INT_WAKE,
    input  wire logic        GLOBAL_INTERRUPT_DISABLE,
    input  wire logic [15:0] PC_IN,
    input  wire logic [3:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [7:0]       RDATA,
    output logic             CORE_RESET,
    output logic [15:0]      PROGRAM_COUNTER,
    output logic [3:0]       CPU_STATUS,
    output logic             IRQ
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic crystal_mode(input logic [1:0] m);
        return (m == `RTS_OSC_XT) || (m == `RTS_OSC_LF);
    endfunction

    function automatic logic [3:0] sta_word(input logic top, input logic global_interrupt_disable,
                                            input logic to_f, input logic pd_f);
        return {top, global_interrupt_disable, to_f, pd_f};
    endfunction

    rts_pkg::rts_regs_type r_ff;
    rts_pkg::rts_regs_type nxt_r;

    logic       osc_rise;
    logic       master_clear_pin_rise;
    logic       timers_done;
    logic [`RTS_EV_W-1:0] ev_set;
    logic [`RTS_EV_W-1:0] ev_clr;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        nxt_r       = r_ff;
        ev_set      = '0;
        ev_clr      = '0;
        osc_rise    = OSC_INPUT_PIN && !r_ff.osc_prev;
        master_clear_pin_rise   = MASTER_CLEAR_PIN_N && !r_ff.master_clear_pin_prev;
        nxt_r.osc_prev  = OSC_INPUT_PIN;
        nxt_r.master_clear_pin_prev = MASTER_CLEAR_PIN_N;
        nxt_r.rdata     = 8'h00;

        // start-up counter runs on oscillator pulses once amplitude is valid
        if (r_ff.ost_active && !r_ff.ost_done && osc_rise && OSC_AMPLITUDE_OK) begin
            if (r_ff.thresh_cnt != `RTS_OSC_THRESH_CNT) begin
                nxt_r.thresh_cnt = r_ff.thresh_cnt + 4'h1;
            end else if (r_ff.ost_cnt == `RTS_OST_PERIODS - 11'h001) begin
                nxt_r.ost_done = 1'b1;
            end else begin
                nxt_r.ost_cnt = r_ff.ost_cnt + 11'h001;
            end
        end
        // power-up delay timer, 96 ms at the system clock
        if (r_ff.state == rts_pkg::RTS_TIMEOUT && !r_ff.powerup_delay_timer_done) begin
            if (r_ff.powerup_delay_timer_cnt >= POWERUP_DELAY_TIMER_CYCLES - 1) begin
                nxt_r.powerup_delay_timer_done = 1'b1;
            end else begin
                nxt_r.powerup_delay_timer_cnt = r_ff.powerup_delay_timer_cnt + 32'h1;
            end
        end
        timers_done = r_ff.powerup_delay_timer_done && (!r_ff.ost_active || r_ff.ost_done);

        unique case (r_ff.state)
            rts_pkg::RTS_POWER_OFF: begin
                nxt_r.core_reset = 1'b1;
                if (POR_SIG) begin
                    nxt_r.state    = rts_pkg::RTS_WAIT_MASTER_CLEAR_PIN;
                    nxt_r.por_seen = 1'b1;
                    ev_set[`RTS_EV_POR] = 1'b1;
                end
            end
            rts_pkg::RTS_WAIT_MASTER_CLEAR_PIN: begin
                nxt_r.core_reset = 1'b1;
                if (MASTER_CLEAR_PIN_N && (master_clear_pin_rise || r_ff.por_seen)) begin
                    nxt_r.state      = rts_pkg::RTS_TIMEOUT;
                    nxt_r.ost_active = r_ff.por_seen && crystal_mode(OSC_MODE);
                    nxt_r.ost_cnt    = 11'h000;
                    nxt_r.thresh_cnt = 4'h0;
                    nxt_r.ost_done   = 1'b0;
                    nxt_r.powerup_delay_timer_cnt   = 32'h0;
                    // clear reset while awake has no time-out
                    nxt_r.powerup_delay_timer_done  = !r_ff.por_seen;
                    nxt_r.por_seen   = 1'b0;
                end
            end
            rts_pkg::RTS_TIMEOUT: begin
                nxt_r.core_reset = 1'b1;
                if (timers_done) begin
                    nxt_r.state      = rts_pkg::RTS_RUN;
                    nxt_r.core_reset = 1'b0;
                    nxt_r.ost_active = 1'b0;
                    ev_set[`RTS_EV_DONE] = 1'b1;
                end
            end
            rts_pkg::RTS_RUN: begin
                if (!MASTER_CLEAR_PIN_N) begin
                    nxt_r.state      = rts_pkg::RTS_WAIT_MASTER_CLEAR_PIN;
                    nxt_r.core_reset = 1'b1;
                    nxt_r.pc         = `RTS_RESET_VECTOR;
                    nxt_r.cpu_sta    = sta_word(1'b1, 1'b1, 1'b1, 1'b1);
                    ev_set[`RTS_EV_MASTER_CLEAR_PIN] = 1'b1;
                end else if (WDT_TIMEOUT) begin
                    // watchdog reset while awake: straight run, no time-out
                    nxt_r.pc      = `RTS_RESET_VECTOR;
                    nxt_r.cpu_sta = sta_word(1'b1, 1'b1, 1'b0, 1'b1);
                    ev_set[`RTS_EV_WDT] = 1'b1;
                end else if (SLEEP_ENTER) begin
                    nxt_r.state   = rts_pkg::RTS_SLEEP;
                    nxt_r.cpu_sta[`RTS_STA_TO_BIT] = 1'b1;
                    nxt_r.cpu_sta[`RTS_STA_PD_BIT] = 1'b0;
                end else if (WDT_CLEAR_INSTR) begin
                    nxt_r.cpu_sta[`RTS_STA_TO_BIT] = 1'b1;
                    nxt_r.cpu_sta[`RTS_STA_PD_BIT] = 1'b1;
                end
            end
            rts_pkg::RTS_SLEEP: begin
                if (!MASTER_CLEAR_PIN_N || WDT_TIMEOUT || INT_WAKE) begin
                    nxt_r.core_reset = 1'b1;
                    nxt_r.ost_active = crystal_mode(OSC_MODE);
                    nxt_r.ost_cnt    = 11'h000;
                    nxt_r.thresh_cnt = 4'h0;
                    nxt_r.ost_done   = 1'b0;
                    nxt_r.state      = rts_pkg::RTS_WAKE_OST;
                    nxt_r.wake_int   = 1'b0;
                    if (!MASTER_CLEAR_PIN_N) begin
                        nxt_r.pc      = `RTS_RESET_VECTOR;
                        nxt_r.cpu_sta = sta_word(1'b1, 1'b1, 1'b1, 1'b0);
                        ev_set[`RTS_EV_MASTER_CLEAR_PIN] = 1'b1;
                    end else if (WDT_TIMEOUT) begin
                        nxt_r.pc      = `RTS_RESET_VECTOR;
                        nxt_r.cpu_sta = sta_word(1'b1, 1'b1, 1'b0, 1'b0);
                        ev_set[`RTS_EV_WDT] = 1'b1;
                    end else begin
                        nxt_r.wake_int = 1'b1;
                        nxt_r.pc       = PC_IN + 16'h0001;
                        nxt_r.cpu_sta  = sta_word(1'b1, GLOBAL_INTERRUPT_DISABLE,
                                                  1'b1, 1'b0);
                        ev_set[`RTS_EV_WAKE] = 1'b1;
                    end
                end
            end
            rts_pkg::RTS_WAKE_OST: begin
                nxt_r.core_reset = 1'b1;
                // clear held low: wait for its release before timing
                if (!MASTER_CLEAR_PIN_N) begin
                    nxt_r.ost_cnt    = 11'h000;
                    nxt_r.thresh_cnt = 4'h0;
                end else if (!r_ff.ost_active || r_ff.ost_done) begin
                    nxt_r.state      = rts_pkg::RTS_RUN;
                    nxt_r.core_reset = 1'b0;
                    nxt_r.ost_active = 1'b0;
                    ev_set[`RTS_EV_DONE] = 1'b1;
                end
            end
        endcase

        // power loss returns to power-off from any state
        if (!POR_SIG) begin
            nxt_r.state      = rts_pkg::RTS_POWER_OFF;
            nxt_r.core_reset = 1'b1;
            nxt_r.pc         = `RTS_RESET_VECTOR;
            nxt_r.cpu_sta    = sta_word(1'b1, 1'b1, 1'b1, 1'b1);
            nxt_r.ost_active = 1'b0;
        end

        // ****************************************************************
        // register port
        // ****************************************************************
        if (WR) begin
            unique case (ADDR)
                `RTS_REG_EVT_STAT: ev_clr = WDATA[`RTS_EV_W-1:0];
                `RTS_REG_EVT_MASK: nxt_r.evt_mask = WDATA[`RTS_EV_W-1:0];
                default: ;
            endcase
        end
        if (RD) begin
            unique case (ADDR)
                `RTS_REG_EVT_STAT: nxt_r.rdata = {3'h0, r_ff.evt_stat};
                `RTS_REG_EVT_MASK: nxt_r.rdata = {3'h0, r_ff.evt_mask};
                `RTS_REG_CPU_STA:  nxt_r.rdata = {4'h0, r_ff.cpu_sta};
                `RTS_REG_PC_LO:    nxt_r.rdata = r_ff.pc[7:0];
                `RTS_REG_PC_HI:    nxt_r.rdata = r_ff.pc[15:8];
                `RTS_REG_STATE:    nxt_r.rdata = {r_ff.ost_done, r_ff.powerup_delay_timer_done,
                                                  r_ff.ost_active, r_ff.core_reset,
                                                  1'b0, r_ff.state};
                default:           nxt_r.rdata = 8'h00;
            endcase
        end
        // set wins over clear
        nxt_r.evt_stat = (r_ff.evt_stat & ~ev_clr) | ev_set;
        nxt_r.irq      = |(nxt_r.evt_stat & r_ff.evt_mask);
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            r_ff            <= '0;
            r_ff.state      <= rts_pkg::RTS_POWER_OFF;
            r_ff.core_reset <= 1'b1;
            r_ff.pc         <= `RTS_RESET_VECTOR;
            r_ff.cpu_sta    <= 4'hF;
            r_ff.osc_prev   <= 1'b0;
            // idle level of the clear pin, so no false rise after reset
            r_ff.master_clear_pin_prev  <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign RDATA           = r_ff.rdata;
    assign CORE_RESET      = r_ff.core_reset;
    assign PROGRAM_COUNTER = r_ff.pc;
    assign CPU_STATUS      = r_ff.cpu_sta;
    assign IRQ             = r_ff.irq;

endmodule

// *** rts_defines.svh ***
`ifndef RTS_DEFINES_SVH
`define RTS_DEFINES_SVH

// start-up counts, in oscillator periods
`define RTS_OST_PERIODS      11'h400
`define RTS_OSC_THRESH_CNT   4'h8

// power-up delay: time in ms and clock rate
`define RTS_POWERUP_DELAY_TIMER_MS          96
`define RTS_CLK_HZ           20000000
`define RTS_POWERUP_DELAY_TIMER_CYCLES      ((`RTS_POWERUP_DELAY_TIMER_MS * `RTS_CLK_HZ) / 1000)

// reset vector
`define RTS_RESET_VECTOR     16'h0000

// oscillator mode encodings
`define RTS_OSC_LF           2'h0
`define RTS_OSC_XT           2'h1
`define RTS_OSC_EC           2'h2
`define RTS_OSC_RC           2'h3

// status field positions inside the 4-bit status value
`define RTS_STA_GLOBAL_INTERRUPT_DISABLE_BIT   2
`define RTS_STA_TO_BIT       1
`define RTS_STA_PD_BIT       0
`define RTS_STA_TOP_BIT      3

// interrupt status / mask bit positions
`define RTS_EV_POR           0
`define RTS_EV_MASTER_CLEAR_PIN          1
`define RTS_EV_WDT           2
`define RTS_EV_WAKE          3
`define RTS_EV_DONE          4
`define RTS_EV_W             5

// register offsets
`define RTS_REG_EVT_STAT     4'h0
`define RTS_REG_EVT_MASK     4'h1
`define RTS_REG_CPU_STA      4'h2
`define RTS_REG_PC_LO        4'h3
`define RTS_REG_PC_HI        4'h4
`define RTS_REG_STATE        4'h5
`define RTS_REG_CTRL         4'h6

`endif

// *** rts_pkg.sv ***
`include "rts_defines.svh"

package rts_pkg;

    typedef enum logic [2:0] {
        RTS_POWER_OFF,
        RTS_WAIT_MASTER_CLEAR_PIN,
        RTS_TIMEOUT,
        RTS_RUN,
        RTS_SLEEP,
        RTS_WAKE_OST
    } rts_state_type;

    typedef struct packed {
        rts_state_type state;
        logic          por_seen;
        logic          ost_active;
        logic [3:0]    thresh_cnt;
        logic [10:0]   ost_cnt;
        logic          ost_done;
        logic [31:0]   powerup_delay_timer_cnt;
        logic          powerup_delay_timer_done;
        logic          osc_prev;
        logic          master_clear_pin_prev;
        logic          wake_int;
        logic [15:0]   pc;
        logic [3:0]    cpu_sta;
        logic          core_reset;
        logic [`RTS_EV_W-1:0] evt_stat;
        logic [`RTS_EV_W-1:0] evt_mask;
        logic          irq;
        logic [7:0]    rdata;
    } rts_regs_type;

endpackage

// *** rts_ext_model.sv ***
`timescale 1ns/1ps
// ****************
// crystal and clear circuit
// ****************
module rts_ext_model (
    input  wire logic clk,
    input  wire logic osc_on,
    input  wire logic btn_n,
    input  wire logic vdd_ok,
    output logic      osc_pin,
    output logic      amp_ok,
    output logic      clr_pin_n
);
    logic       ph_ff   = 1'b0;
    logic [2:0] warm_ff = 3'h0;
    always_ff @(posedge clk) begin
        ph_ff <= osc_on && !ph_ff;
        if (!osc_on) begin
            warm_ff <= 3'h0;
        end else if (warm_ff != 3'h7) begin
            warm_ff <= warm_ff + 3'h1;
        end
    end
    // stands low when stopped
    assign osc_pin   = ph_ff && osc_on;
    assign amp_ok    = (warm_ff == 3'h7);
    assign clr_pin_n = btn_n && vdd_ok;
endmodule

// *** rts_sequencer_sva.sv ***
`timescale 1ns/1ps
// ****************
// sequencer checks
// ****************
module rts_chk #(
    parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = 50
) (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        POR_SIG,
    input wire logic        MASTER_CLEAR_PIN_N,
    input wire logic        OSC_INPUT_PIN,
    input wire logic        OSC_AMPLITUDE_OK,
    input wire logic [1:0]  OSC_MODE,
    input wire logic        WDT_TIMEOUT,
    input wire logic        WDT_CLEAR_INSTR,
    input wire logic [3:0]  ADDR,
    input wire logic        RD,
    input wire logic [7:0]  RDATA,
    input wire logic        CORE_RESET,
    input wire logic [15:0] PROGRAM_COUNTER,
    input wire logic [3:0]  CPU_STATUS
);
    logic [31:0] por_cnt_ff;
    logic [10:0] osc_cnt_ff;
    logic        osc_prev_ff;
    logic        boot_ff;
    // cycles since power-on, qualified osc edges
    always_ff @(posedge CLK) begin
        osc_prev_ff <= OSC_INPUT_PIN;
        if (!RST_N || !POR_SIG) begin
            por_cnt_ff <= 32'h0;
            osc_cnt_ff <= 11'h0;
            boot_ff    <= 1'b1;
        end else begin
            if (por_cnt_ff != 32'hFFFFFFFF) begin
                por_cnt_ff <= por_cnt_ff + 32'h1;
            end
            // edges counted only while the core is held in reset
            if (!CORE_RESET) begin
                osc_cnt_ff <= 11'h0;
                boot_ff    <= 1'b0;
            end else if (OSC_AMPLITUDE_OK && OSC_INPUT_PIN && !osc_prev_ff
                         && osc_cnt_ff != 11'h7FF) begin
                osc_cnt_ff <= osc_cnt_ff + 11'h1;
            end
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_clr_low;
        !MASTER_CLEAR_PIN_N ##1 !MASTER_CLEAR_PIN_N;
    endsequence
    sequence s_wdt_evt;
        WDT_TIMEOUT && !CORE_RESET && POR_SIG && MASTER_CLEAR_PIN_N;
    endsequence
    property p_rst_init;
        $rose(RST_N) |-> CORE_RESET && PROGRAM_COUNTER == 16'h0000 && CPU_STATUS == 4'hF;
    endproperty
    property p_clr_hold;
        s_clr_low |-> CORE_RESET;
    endproperty
    property p_powerup_delay_timer_min;
        $fell(CORE_RESET) |-> por_cnt_ff >= POWERUP_DELAY_TIMER_CYCLES;
    endproperty
    property p_ost_min;
        $fell(CORE_RESET) && !OSC_MODE[1] && (boot_ff || !CPU_STATUS[0])
            |-> osc_cnt_ff >= 11'h400;
    endproperty
    property p_pc_vec;
        $fell(CORE_RESET) && CPU_STATUS[0] |-> PROGRAM_COUNTER == 16'h0000;
    endproperty
    property p_sta_enc;
        CPU_STATUS[3] && (CPU_STATUS[2] || CPU_STATUS[1:0] == 2'h2);
    endproperty
    property p_wdt_to;
        s_wdt_evt |=> !CPU_STATUS[1];
    endproperty
    property p_watchdog_clear_instruction;
        WDT_CLEAR_INSTR && !WDT_TIMEOUT && !CORE_RESET |=> CPU_STATUS[1:0] == 2'h3;
    endproperty
    property p_rd_sta;
        RD && ADDR == 4'h2 |=> RDATA == {4'h0, $past(CPU_STATUS)};
    endproperty
    a_rst_init: assert property (p_rst_init) else $error("bad reset values");
    a_clr_hold: assert property (p_clr_hold) else $error("clear low not held");
    a_powerup_delay_timer_min: assert property (p_powerup_delay_timer_min) else $error("power-up delay short");
    a_ost_min: assert property (p_ost_min) else $error("start-up count short");
    a_pc_vec: assert property (p_pc_vec) else $error("pc not at vector");
    a_sta_enc: assert property (p_sta_enc) else $error("bad status code");
    a_wdt_to: assert property (p_wdt_to) else $error("timeout flag kept");
    a_watchdog_clear_instruction: assert property (p_watchdog_clear_instruction) else $error("flags not set");
    a_rd_sta: assert property (p_rd_sta) else $error("status read wrong");
endmodule

bind rts_sequencer rts_chk #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES)) u_chk (
    .CLK, .RST_N, .POR_SIG, .MASTER_CLEAR_PIN_N, .OSC_INPUT_PIN, .OSC_AMPLITUDE_OK,
    .OSC_MODE, .WDT_TIMEOUT, .WDT_CLEAR_INSTR, .ADDR, .RD, .RDATA, .CORE_RESET,
    .PROGRAM_COUNTER, .CPU_STATUS
);

// *** tb_top.sv ***
`timescale 1ns/1ps
`include "rts_defines.svh"
// ****************
// sequencer bench
// ****************
module tb_top;
    logic        clk, rst_n = 1'b0, por = 1'b0, osc_on = 1'b0, btn_n = 1'b1;
    logic        vdd_ok = 1'b1, gid = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [1:0]  mode = `RTS_OSC_XT;
    logic [3:0]  ev = 4'h0, addr = 4'h0, sta;
    logic [7:0]  wdata = 8'h00, rdata, d;
    logic [15:0] pc_in = 16'h1234, pc;
    logic        crst, irq, osc, amp, master_clear_pin_n;
    int          failures = 0, checked = 0, n = 0, cyc = 0;
    rts_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(50)) u_dut (
        .CLK(clk), .RST_N(rst_n), .POR_SIG(por), .MASTER_CLEAR_PIN_N(master_clear_pin_n),
        .OSC_INPUT_PIN(osc), .OSC_AMPLITUDE_OK(amp), .OSC_MODE(mode), .SLEEP_ENTER(ev[0]),
        .WDT_TIMEOUT(ev[1]), .WDT_CLEAR_INSTR(ev[2]), .INT_WAKE(ev[3]),
        .GLOBAL_INTERRUPT_DISABLE(gid), .PC_IN(pc_in), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .CORE_RESET(crst), .PROGRAM_COUNTER(pc),
        .CPU_STATUS(sta), .IRQ(irq)
    );
    rts_ext_model u_ext (.clk(clk), .osc_on(osc_on), .btn_n(btn_n), .vdd_ok(vdd_ok),
        .osc_pin(osc), .amp_ok(amp), .clr_pin_n(master_clear_pin_n));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic final_report;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] s, input logic [23:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 4'h0;
    endtask
    // bounded wait for core release, n = cycles waited
    task automatic wait_rel;
        n = 0;
        @(posedge clk);
        #1;
        while (crst !== 1'b0 && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("release", crst, 1'b0);
    endtask
    task automatic clr_pulse;
        @(posedge clk);
        btn_n <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk("clr hold", crst, 1'b1);
        @(posedge clk);
        btn_n <= 1'b1;
        wait_rel();
        chk("clr len", n <= 3, 1'b1);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("rst", {crst, irq, sta, pc}, {2'h2, 4'hF, 16'h0});
        rd_reg(4'h2);
        chk("sta rd", d, 8'h0F);
        rd_reg(4'hF);
        chk("unmapped", d, 8'h00);
        @(posedge clk);
        osc_on <= 1'b1;
        por <= 1'b1;
        wait_rel();
        chk("powerup", {n >= 2048, irq, pc, sta}, {2'h2, 16'h0, 4'hF});
        rd_reg(4'h0);
        chk("por evt", d[0], 1'b1);
        wr_reg(4'h1, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk("irq on", irq, 1'b1);
        wr_reg(4'h0, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk("irq off", irq, 1'b0);
        wr_reg(4'h1, 8'h00);
        $display("test powerup done");
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            mode <= (i == 2) ? `RTS_OSC_RC : ((i == 1) ? `RTS_OSC_LF : `RTS_OSC_XT);
            gid <= (i == 2);
            pulse(4'h1);
            pulse(4'h8);
            wait_rel();
            chk("wake len", (i == 2) ? n <= 3 : n >= 2048, 1'b1);
            chk("wake", {pc, sta}, {16'h1235, (i == 2) ? 4'hE : 4'hA});
        end
        rd_reg(4'h3);
        chk("pc lo", d, 8'h35);
        rd_reg(4'h4);
        chk("pc hi", d, 8'h12);
        $display("test wake done");
        pulse(4'h2);
        @(posedge clk);
        #1;
        chk("wdt run", {crst, pc, sta}, {1'b0, 16'h0, 4'hD});
        pulse(4'h4);
        @(posedge clk);
        #1;
        chk("watchdog_clear_instruction", sta, 4'hF);
        pulse(4'h1);
        pulse(4'h2);
        wait_rel();
        chk("wdt sleep", {pc, sta}, {16'h0, 4'hC});
        pulse(4'h1);
        clr_pulse();
        chk("clr sleep", {pc, sta}, {16'h0, 4'hE});
        clr_pulse();
        chk("clr run", {pc, sta}, {16'h0, 4'hF});
        $display("test resets done");
        @(posedge clk);
        por <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("por off", crst, 1'b1);
        @(posedge clk);
        por <= 1'b1;
        wait_rel();
        chk("powerup_delay_timer rc", n >= 50 && n <= 60, 1'b1);
        $display("test power cycle done");
        final_report();
    end
endmodule
